// *** hdl/ocl_top.sv ***
// Cycle-by-cycle peak overcurrent limiter with sense gain and compensation
// configuration, reached as an AHB-Lite slave.
// Assumes pwm_demand comes from the modulator on hclk; the comparator and
// switching clock arrive from outside and are synchronised here.
//
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module ocl_top
  import ocl_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sw_clk_pin,
  input  wire logic        oc_comp_pin,
  input  wire logic        pwm_demand,
  output logic             hs_drive,
  output logic      [4:0]  overcurrent_threshold,
  output logic      [4:0]  sense_gain_trim,
  output logic      [3:0]  comp_zero_freq_select,
  output logic      [3:0]  comp_gain_select,
  output logic             irq
);

  ocl_oc_ctrl_t           oc_ctrl_reg;
  logic [4:0]             trim_reg;
  logic [7:0]             comp_reg;
  logic                   flag_reg;
  logic                   mask_reg;
  ocl_aphase_t            aphase_reg;
  logic                   wr_pend_reg;
  logic                   rd_pend_reg;
  logic                   sw_clk_sync;
  logic                   comp_sync;
  logic                   sw_clk_prev_reg;
  logic                   terminated_reg;
  logic                   trip_in_cycle_reg;
  logic                   clean_cycle_reg;
  logic [OCL_BLANK_W-1:0] blank_cnt_reg;
  logic                   hs_prev_reg;
  logic                   cycle_start;
  logic                   hs_rise;
  logic                   trip_now;
  logic                   bus_take;
  logic                   flag_clear_req;

  //////////////////////////////////////////////////////////////////////////////
  // Blanking count for a select code; used by the loader and the checks.
  function automatic logic [OCL_BLANK_W-1:0] blank_count(input logic [1:0] sel);
    case (sel)
      2'h0:    blank_count = OCL_BLANK_W'(OCL_BLANK0_CYC);
      2'h1:    blank_count = OCL_BLANK_W'(OCL_BLANK1_CYC);
      2'h2:    blank_count = OCL_BLANK_W'(OCL_BLANK2_CYC);
      default: blank_count = OCL_BLANK_W'(OCL_BLANK3_CYC);
    endcase
  endfunction

  // Read value of a register; unmapped words read as zero.
  function automatic logic [31:0] read_word(input logic [7:0] addr);
    case (addr)
      OCL_OFF_OC_CTRL:  read_word = {24'h000000, oc_ctrl_reg};
      OCL_OFF_GAIN:     read_word = {27'h0000000, trim_reg};
      OCL_OFF_COMP:     read_word = {24'h000000, comp_reg};
      OCL_OFF_IRQ_STAT: read_word = {31'h00000000, flag_reg};
      OCL_OFF_IRQ_MASK: read_word = {31'h00000000, mask_reg};
      OCL_OFF_LIVE:     read_word = {28'h0000000, clean_cycle_reg, trip_in_cycle_reg,
                                     terminated_reg, hs_drive};
      default:          read_word = 32'h00000000;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Outside inputs pass the three-stage filter before any logic sees them.
  ocl_sync3 u_sync_sw (
    .clk       (hclk),
    .rst_n     (hresetn),
    .async_in  (sw_clk_pin),
    .level_out (sw_clk_sync)
  );

  ocl_sync3 u_sync_comp (
    .clk       (hclk),
    .rst_n     (hresetn),
    .async_in  (oc_comp_pin),
    .level_out (comp_sync)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave. Writes finish with no wait; reads add one wait state so a read
  // right after a write always returns the freshly written value.
  assign bus_take       = hsel && htrans[1] && hready;
  assign flag_clear_req = wr_pend_reg && (aphase_reg.addr == OCL_OFF_IRQ_STAT) &&
                          hwdata[OCL_FLAG_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aphase_reg  <= '0;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
    end else begin
      wr_pend_reg <= bus_take && hwrite;
      rd_pend_reg <= bus_take && !hwrite;
      if (bus_take) begin
        aphase_reg.write <= hwrite;
        aphase_reg.addr  <= {haddr[7:2], 2'b00};
      end
    end
  end

  // Wait state and read data, both from flip-flops.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h00000000;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (bus_take && !hwrite) begin
        hreadyout <= 1'b0;
      end else if (rd_pend_reg) begin
        hreadyout <= 1'b1;
        hrdata    <= read_word(aphase_reg.addr);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oc_ctrl_reg <= OCL_RST_OC_CTRL;
      trim_reg    <= OCL_RST_TRIM;
      comp_reg    <= OCL_RST_COMP;
      mask_reg    <= OCL_RST_MASK;
    end else if (wr_pend_reg) begin
      case (aphase_reg.addr)
        OCL_OFF_OC_CTRL:  oc_ctrl_reg <= hwdata[7:0];
        OCL_OFF_GAIN:     trim_reg    <= hwdata[OCL_TRIM_LSB +: 5];
        OCL_OFF_COMP:     comp_reg    <= hwdata[7:0];
        OCL_OFF_IRQ_MASK: mask_reg    <= hwdata[OCL_FLAG_BIT];
        default:          mask_reg    <= mask_reg;
      endcase
    end
  end

  // Configuration outputs mirror their registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overcurrent_threshold <= OCL_RST_OC_CTRL[OCL_THRESH_LSB +: 5];
      sense_gain_trim       <= OCL_RST_TRIM;
      comp_zero_freq_select <= OCL_RST_COMP[OCL_ZERO_LSB +: 4];
      comp_gain_select      <= OCL_RST_COMP[OCL_CGAIN_LSB +: 4];
    end else begin
      overcurrent_threshold <= oc_ctrl_reg.threshold;
      sense_gain_trim       <= trim_reg;
      comp_zero_freq_select <= comp_reg[OCL_ZERO_LSB +: 4];
      comp_gain_select      <= comp_reg[OCL_CGAIN_LSB +: 4];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Switching cycle edges and blanking.
  assign cycle_start = sw_clk_sync && !sw_clk_prev_reg;
  assign hs_rise     = hs_drive && !hs_prev_reg;
  assign trip_now    = oc_ctrl_reg.enable && hs_drive && !hs_rise &&
                       (blank_cnt_reg == '0) && comp_sync;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_clk_prev_reg <= 1'b0;
      hs_prev_reg     <= 1'b0;
    end else begin
      sw_clk_prev_reg <= sw_clk_sync;
      hs_prev_reg     <= hs_drive;
    end
  end

  // blank from rising edge
  // The counter reloads on every drive rise, so a short pulse is blanked whole.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blank_cnt_reg <= '0;
    end else if (hs_rise) begin
      blank_cnt_reg <= blank_count(oc_ctrl_reg.blank_sel) - OCL_BLANK_W'(1);
    end else if (!hs_drive) begin
      blank_cnt_reg <= '0;
    end else if (blank_cnt_reg != '0) begin
      blank_cnt_reg <= blank_cnt_reg - OCL_BLANK_W'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // High-side drive gating.
  // cut and restore
  // The termination latch only releases at a cycle start, so a trip can never
  // let the drive back on inside the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      terminated_reg <= 1'b0;
    end else if (trip_now) begin
      terminated_reg <= 1'b1;
    end else if (cycle_start) begin
      terminated_reg <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs_drive <= 1'b0;
    end else begin
      hs_drive <= pwm_demand && !trip_now && (!terminated_reg || cycle_start);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Clean-cycle tracking for the clear qualification.
  // one clean cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trip_in_cycle_reg <= 1'b0;
      clean_cycle_reg   <= 1'b0;
    end else begin
      if (trip_now) begin
        trip_in_cycle_reg <= 1'b1;
        clean_cycle_reg   <= 1'b0;
      end else if (cycle_start) begin
        trip_in_cycle_reg <= 1'b0;
        clean_cycle_reg   <= clean_cycle_reg || !trip_in_cycle_reg;
      end
    end
  end

  // flag set and clear
  // Set wins over a simultaneous clear; the mask never gates the set, but the enable does.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_reg <= 1'b0;
    end else if (trip_now) begin
      flag_reg <= 1'b1;
    end else if (flag_clear_req && clean_cycle_reg) begin
      flag_reg <= 1'b0;
    end
  end

  // Interrupt line, high while the flag is set and unmasked.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (flag_reg || trip_now) && mask_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_trip;
    trip_now;
  endsequence

  sequence s_drive_off;
    !hs_drive ##0 terminated_reg;
  endsequence

  property p_trip_cuts;
    @(posedge hclk) disable iff (!hresetn) s_trip |=> s_drive_off;
  endproperty
  a_trip_cuts: assert property (p_trip_cuts) else $error("drive not cut on trip");

  property p_flag_sets;
    @(posedge hclk) disable iff (!hresetn) trip_now |=> flag_reg;
  endproperty
  a_flag_sets: assert property (p_flag_sets) else $error("flag not set on trip");

  property p_restore;
    @(posedge hclk) disable iff (!hresetn)
      terminated_reg && cycle_start && pwm_demand && !trip_now |=> hs_drive;
  endproperty
  a_restore: assert property (p_restore) else $error("drive not restored");

  property p_hold_off;
    @(posedge hclk) disable iff (!hresetn)
      terminated_reg && !cycle_start |=> !hs_drive;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("drive back inside cycle");

  property p_no_self_clear;
    @(posedge hclk) disable iff (!hresetn)
      flag_reg && !(flag_clear_req && clean_cycle_reg) |=> flag_reg;
  endproperty
  a_no_self_clear: assert property (p_no_self_clear) else $error("flag lost");

  property p_blank_mask;
    @(posedge hclk) disable iff (!hresetn) blank_cnt_reg != '0 && !terminated_reg |=> !terminated_reg;
  endproperty
  a_blank_mask: assert property (p_blank_mask) else $error("trip in blanking");

  property p_blank_load;
    @(posedge hclk) disable iff (!hresetn)
      hs_rise |=> blank_cnt_reg == blank_count($past(oc_ctrl_reg.blank_sel)) - OCL_BLANK_W'(1);
  endproperty
  a_blank_load: assert property (p_blank_load) else $error("blanking count wrong");

  property p_disabled;
    @(posedge hclk) disable iff (!hresetn) !oc_ctrl_reg.enable && !flag_reg |=> !flag_reg;
  endproperty
  a_disabled: assert property (p_disabled) else $error("trip while disabled");

  property p_trip_needs_drive;
    @(posedge hclk) disable iff (!hresetn) $rose(terminated_reg) |-> $past(hs_drive) && $past(hs_drive, 2);
  endproperty
  a_trip_needs_drive: assert property (p_trip_needs_drive) else $error("sample w/o drive");

  property p_thresh_out;
    @(posedge hclk) disable iff (!hresetn)
      ##1 overcurrent_threshold == $past(oc_ctrl_reg.threshold);
  endproperty
  a_thresh_out: assert property (p_thresh_out) else $error("threshold not driven");

endmodule
`default_nettype wire

// *** hdl/ocl_pkg.sv ***
// Package for the overcurrent limiter: register map, field layouts,
// reset values, blanking times and the structs that carry related fields.
// Assumes a 250 MHz hclk and an AHB-Lite master with 32-bit data.
package ocl_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets, one aligned word each.
  localparam logic [7:0] OCL_OFF_OC_CTRL  = 8'h00;
  localparam logic [7:0] OCL_OFF_GAIN     = 8'h04;
  localparam logic [7:0] OCL_OFF_COMP     = 8'h08;
  localparam logic [7:0] OCL_OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OCL_OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OCL_OFF_LIVE     = 8'h14;

  // Field positions.
  localparam int OCL_EN_BIT      = 7;
  localparam int OCL_BLANK_LSB   = 5;
  localparam int OCL_THRESH_LSB  = 0;
  localparam int OCL_TRIM_LSB    = 0;
  localparam int OCL_ZERO_LSB    = 4;
  localparam int OCL_CGAIN_LSB   = 0;
  localparam int OCL_FLAG_BIT    = 0;

  // Values after reset.
  localparam logic [7:0] OCL_RST_OC_CTRL = 8'h00;
  localparam logic [4:0] OCL_RST_TRIM    = 5'h00;
  localparam logic [7:0] OCL_RST_COMP    = 8'h00;
  localparam logic       OCL_RST_MASK    = 1'b0;

  // Fixed gain ahead of the converter, untouched by the trim.
  localparam int OCL_FIXED_GAIN_DB = 6;

  // Clock period and blanking times, each in ns.
  localparam int OCL_CLK_PERIOD_NS = 4;
  localparam int OCL_BLANK0_NS     = 110;
  localparam int OCL_BLANK1_NS     = 200;
  localparam int OCL_BLANK2_NS     = 380;
  localparam int OCL_BLANK3_NS     = 740;

  // Blanking is a least time, so each count rounds up.
  localparam int OCL_BLANK0_CYC = (OCL_BLANK0_NS + OCL_CLK_PERIOD_NS - 1) / OCL_CLK_PERIOD_NS;
  localparam int OCL_BLANK1_CYC = (OCL_BLANK1_NS + OCL_CLK_PERIOD_NS - 1) / OCL_CLK_PERIOD_NS;
  localparam int OCL_BLANK2_CYC = (OCL_BLANK2_NS + OCL_CLK_PERIOD_NS - 1) / OCL_CLK_PERIOD_NS;
  localparam int OCL_BLANK3_CYC = (OCL_BLANK3_NS + OCL_CLK_PERIOD_NS - 1) / OCL_CLK_PERIOD_NS;
  localparam int OCL_BLANK_W    = 8;

  // Overcurrent control register layout.
  typedef struct packed {
    logic       enable;
    logic [1:0] blank_sel;
    logic [4:0] threshold;
  } ocl_oc_ctrl_t;

  // Captured AHB address phase.
  typedef struct packed {
    logic       write;
    logic [7:0] addr;
  } ocl_aphase_t;

endpackage

// *** hdl/ocl_sync3.sv ***
// Three-stage input synchroniser with an agreement filter.
// Assumes the input is asynchronous to clk; the output only moves once
// the second and third stages agree on a new level.
`timescale 1ns/1ns
`default_nettype none
module ocl_sync3
  import ocl_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      level_out
);

  logic meta_reg;
  logic s2_reg;
  logic s3_reg;

  //////////////////////////////////////////////////////////////////////////////
  // The first stage feeds only the second, so metastability stays contained.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      s2_reg   <= 1'b0;
      s3_reg   <= 1'b0;
    end else begin
      meta_reg <= async_in;
      s2_reg   <= meta_reg;
      s3_reg   <= s2_reg;
    end
  end

  // A change is accepted only when two settled stages agree.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_out <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      level_out <= s3_reg;
    end
  end

endmodule
`default_nettype wire

// *** test/ocl_stage_model.sv ***
// Power stage and modulator model: switching clock, demand and the
// high-side comparator. Assumes hclk at 4 ns and a registered hs_drive.
`timescale 1ns/1ns
`default_nettype none
module ocl_stage_model #(
  parameter int PERIOD = 400,
  parameter int DUTY   = 350
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic hs_drive,
  input  wire logic over,
  output logic      sw_clk_pin,
  output logic      oc_comp_pin,
  output logic      pwm_demand
);
  int cnt;

  ////////////////////////////////////////////////////////////////////////////
  // One phase counter gives the switching clock and the modulator demand.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt        <= 0;
      sw_clk_pin <= 1'b0;
      pwm_demand <= 1'b0;
    end else begin
      cnt        <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      sw_clk_pin <= (cnt < PERIOD / 2);
      pwm_demand <= (cnt < DUTY);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // A drop only exists while the switch conducts, so an idle switch reads low.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oc_comp_pin <= 1'b0;
    end else begin
      oc_comp_pin <= over & hs_drive;
    end
  end
endmodule
`default_nettype wire

// *** test/overcurrent_limit_ctrl_test.sv ***
// Self-checking bench for the overcurrent limiter over AHB-Lite.
// Assumes the stage model beside it and hready looped from hreadyout.
`timescale 1ns/1ns
`default_nettype none
module overcurrent_limit_ctrl_test;
  import ocl_pkg::*;
  localparam int PERIOD = 400;
  localparam int DUTY   = 350;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic        over;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  wire logic   hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        sw_clk_pin;
  logic        oc_comp_pin;
  logic        pwm_demand;
  logic        hs_drive;
  logic [4:0]  overcurrent_threshold;
  logic [4:0]  sense_gain_trim;
  logic [3:0]  comp_zero_freq_select;
  logic [3:0]  comp_gain_select;
  logic        irq;
  int          errors;
  int          n_checks;

  assign hready = hreadyout;

  ocl_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sw_clk_pin(sw_clk_pin), .oc_comp_pin(oc_comp_pin),
    .pwm_demand(pwm_demand), .hs_drive(hs_drive), .overcurrent_threshold(overcurrent_threshold),
    .sense_gain_trim(sense_gain_trim), .comp_zero_freq_select(comp_zero_freq_select),
    .comp_gain_select(comp_gain_select), .irq(irq));

  ocl_stage_model #(.PERIOD(PERIOD), .DUTY(DUTY)) u_stage (.hclk(hclk), .hresetn(hresetn),
    .hs_drive(hs_drive), .over(over), .sw_clk_pin(sw_clk_pin), .oc_comp_pin(oc_comp_pin),
    .pwm_demand(pwm_demand));

  ////////////////////////////////////////////////////////////////////////////
  // Clock of 4 ns.
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hangs are cut well past the expected run of some fourteen switching cycles.
  initial begin
    #200000;
    errors++;
    end_of_test();
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One single transfer; entered just after a rising edge, waits on hready.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    chk("address ready", 32'(hreadyout), 32'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    chk("data ready", 32'(hreadyout), 32'h1);
    chk("response", 32'(hresp), 32'h0);
    rd = hrdata;
  endtask

  // Cycles until the next drive rise (wt), then how long it stays high (hi).
  task automatic measure(output int hi, output int wt);
    wt = 0;
    while (hs_drive !== 1'b0 && wt < 1000) begin
      @(posedge hclk);
      wt++;
    end
    while (hs_drive !== 1'b1 && wt < 2000) begin
      @(posedge hclk);
      wt++;
    end
    hi = 0;
    while (hs_drive === 1'b1 && hi < 1000) begin
      @(posedge hclk);
      hi++;
    end
    // A wait that runs out is a failure, not a short pulse.
    chk("measure limit", 32'(wt < 2000 && hi < 1000), 32'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    logic [31:0] rd;
    logic [7:0]  ta [4];
    logic [31:0] tw [4];
    logic [31:0] te [4];
    int          bc [4];
    int          hi;
    int          hs;
    int          wt;
    ta = '{OCL_OFF_OC_CTRL, OCL_OFF_GAIN, OCL_OFF_COMP, 8'h3C};
    tw = '{32'hFFFFFF7F, 32'hFFFFFFFF, 32'hFFFFFFA5, 32'h12345678};
    te = '{32'h0000007F, 32'h0000001F, 32'h000000A5, 32'h00000000};
    bc = '{OCL_BLANK0_CYC, OCL_BLANK1_CYC, OCL_BLANK2_CYC, OCL_BLANK3_CYC};
    errors = 0;
    n_checks = 0;
    hresetn = 1'b0;
    hsel = 1'b1;
    hsize = 3'h2;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    over = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 5; i++) begin
      xfer(1'b0, 8'(4 * i), 32'h0, rd);
      chk("reset value", rd, 32'h0);
    end
    // The live word shows the drive following demand; the clean bit depends on cycle phase.
    xfer(1'b0, OCL_OFF_LIVE, 32'h0, rd);
    chk("live after reset", rd & 32'hFFFFFFF7, 32'h1);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, ta[i], tw[i], rd);
      xfer(1'b0, ta[i], 32'h0, rd);
      chk("readback", rd, te[i]);
    end
    chk("threshold port", 32'(overcurrent_threshold), 32'h1F);
    chk("trim port", 32'(sense_gain_trim), 32'h1F);
    chk("zero port", 32'(comp_zero_freq_select), 32'hA);
    chk("gain port", 32'(comp_gain_select), 32'h5);
    $display("test registers done");
    over <= 1'b1;
    measure(hi, wt);
    hs = hi;
    measure(hi, wt);
    chk("disabled drive", 32'((hs + hi) / 2 >= DUTY - 8), 32'h1);
    xfer(1'b0, OCL_OFF_IRQ_STAT, 32'h0, rd);
    chk("disabled flag", rd, 32'h0);
    $display("test disable done");
    for (int s = 0; s < 4; s++) begin
      xfer(1'b1, OCL_OFF_OC_CTRL, 32'h00000090 | 32'(s << 5), rd);
      measure(hi, wt);
      chk("blank first", 32'(hi >= bc[s] && hi <= bc[s] + 4), 32'h1);
      measure(hi, wt);
      chk("restart", 32'(wt >= 1 && wt <= PERIOD), 32'h1);
      chk("blank again", 32'(hi >= bc[s] && hi <= bc[s] + 4), 32'h1);
    end
    xfer(1'b0, OCL_OFF_IRQ_STAT, 32'h0, rd);
    chk("flag masked", rd, 32'h1);
    chk("irq masked", 32'(irq), 32'h0);
    xfer(1'b1, OCL_OFF_IRQ_MASK, 32'h1, rd);
    // The mask lands at the write's last edge and the irq flop follows one edge later.
    repeat (2) @(posedge hclk);
    chk("irq unmasked", 32'(irq), 32'h1);
    $display("test trip done");
    xfer(1'b1, OCL_OFF_IRQ_STAT, 32'h1, rd);
    xfer(1'b0, OCL_OFF_IRQ_STAT, 32'h0, rd);
    chk("early clear", rd, 32'h1);
    over <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      measure(hi, wt);
    end
    chk("clean drive", 32'(hi >= DUTY - 8), 32'h1);
    xfer(1'b0, OCL_OFF_IRQ_STAT, 32'h0, rd);
    chk("flag sticky", rd, 32'h1);
    xfer(1'b1, OCL_OFF_IRQ_STAT, 32'h1, rd);
    xfer(1'b0, OCL_OFF_IRQ_STAT, 32'h0, rd);
    chk("late clear", rd, 32'h0);
    chk("irq cleared", 32'(irq), 32'h0);
    $display("test clear done");
    end_of_test();
  end
endmodule
`default_nettype wire
